// file: bench/difd_field_model.sv
/*
 field side of the input block: contact levels plus the internal
 pulse source; assumes pt_drive pulls a healthy point high.
*/
`timescale 1ns/1ps
`default_nettype none

module difd_field_model (
  input wire logic [15:0] level,
  input wire logic [15:0] broken,
  input wire logic [15:0] pt_drive,
  output logic [15:0] field_in
);
  // broken points never follow the pulse, so the test fails unless level holds them high
  assign field_in = level | (pt_drive & ~broken);
endmodule

`default_nettype wire

// file: bench/difd_top_assertions.sv
/*
 port checker for difd_top: bus handshake, value cause, sticky
 faults and pulse drive; bound to the top from the bench file.
*/
`timescale 1ns/1ps
`default_nettype none

module difd_top_assertions #(
  parameter int TICK_CYC = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] field_in,
  input wire logic comm_lost,
  input wire logic [15:0] chan_val,
  input wire logic [15:0] pt_drive,
  input wire logic fault_req
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic req;
  assign req = avs_read || avs_write;

  sequence pt_start;
    $rose(|pt_drive);
  endsequence
  // a pulse lasts 8 ticks, so 8 cycles is a safe floor
  sequence pt_pulse;
    (|pt_drive) [*8];
  endsequence

  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("request answered without wait");
  one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("second wait cycle");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait without request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved while idle");
  // sync chain delays a rise by at least two cycles
  val_cause_a: assert property (!comm_lost |->
    ((chan_val & ~$past(chan_val) & ~$past(field_in, 2)) == 16'h0000))
    else $error("value rose without input");
  fault_sticky_a: assert property ($fell(fault_req) |-> $past(avs_write))
    else $error("fault cleared without write");
  pt_onehot_a: assert property ($onehot0(pt_drive))
    else $error("two channels pulsed");
  pt_hold_a: assert property (pt_start |=> pt_pulse)
    else $error("pulse cut short");
endmodule

`default_nettype wire

// file: bench/tb.sv
/*
 bench top: Avalon tasks and scenario sequence for difd_top;
 assumes the tick shortened to 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int TK = 4;
  logic mclk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic cl = 1'b0, tbr = 1'b0, at = 1'b0, waitr, freq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdd, q;
  logic [15:0] lvl = 16'h0, brk = 16'h0, ow = 16'h0, sp = 16'h0, fin, cv, ptd;
  logic [1:0] fpl = 2'h0;
  int fail_count = 0;
  int n_tests = 0;

  difd_top #(.TICK_CYC(TK)) dut (.mclk(mclk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdd),
    .avs_waitrequest(waitr), .field_in(fin), .open_wire_in(ow), .short_pwr_in(sp),
    .tb_removed_in(tbr), .fp_lost_in(fpl), .comm_lost(cl), .auto_tick(at),
    .chan_val(cv), .pt_drive(ptd), .fault_req(freq));
  difd_field_model field (.level(lvl), .broken(brk), .pt_drive(ptd), .field_in(fin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    // only the watchdog ends a wait that never gets an answer
    do
    begin
      @(posedge mclk);
    end
    while (waitr !== 1'b0);
    q = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
    forever #12.5 mclk = ~mclk;

  initial
  begin
    int n;
    cyc(12);
    rst_n <= 1'b1;
    rdc(8'h00, 32'h0c03);
    rdc(8'h40, 32'h02051);
    wrt_l: bus(1'b1, 8'h40, 32'h2007);
    bus(1'b1, 8'h44, 32'h2000);
    lvl <= 16'h0003;
    cyc(6);
    chk(cv, 16'h0002);
    lvl <= 16'h0002;
    cyc(2);
    lvl <= 16'h0003;
    cyc(8);
    chk(cv, 16'h0002);
    cyc(30);
    chk(cv, 16'h0003);
    rdc(8'h04, 32'h0003);
    bus(1'b1, 8'h00, 32'h0c07);
    cl <= 1'b1;
    lvl <= 16'h0001;
    cyc(20);
    chk(cv, 16'h0003);
    bus(1'b1, 8'h00, 32'h0c03);
    cyc(2);
    chk(cv, 16'h0000);
    cl <= 1'b0;
    bus(1'b1, 8'h00, 32'h0c7b);
    tbr <= 1'b1;
    fpl <= 2'b11;
    cyc(6);
    chk(cv, 16'h0000);
    rdc(8'h08, 32'h13);
    rdc(8'h10, 32'h30000);
    chk(freq, 1'b1);
    tbr <= 1'b0;
    fpl <= 2'b00;
    bus(1'b1, 8'h10, 32'h7ffff);
    rdc(8'h10, 32'h0);
    chk(freq, 1'b0);
    bus(1'b1, 8'h00, 32'h0c03);
    tbr <= 1'b1;
    cyc(6);
    rdc(8'h10, 32'h0);
    rdc(8'h08, 32'h1);
    bus(1'b1, 8'h00, 32'h0c01);
    rdc(8'h08, 32'h0);
    tbr <= 1'b0;
    bus(1'b1, 8'h00, 32'h0c03);
    ow <= 16'h0004;
    sp <= 16'h0004;
    for (int t = 0; t < 3; t++)
    begin
      bus(1'b1, 8'h48, 32'he000 | (32'(t) << 9));
      cyc(4);
      rdc(8'h88, {30'h0, t == 2, t > 0});
      rdc(8'h10, 32'h0);
    end
    bus(1'b1, 8'h48, 32'h2e400);
    cyc(3);
    rdc(8'h10, 32'h4);
    bus(1'b1, 8'h00, 32'h0c02);
    rdc(8'h88, 32'h0);
    bus(1'b1, 8'h00, 32'h0c03);
    bus(1'b1, 8'h48, 32'h2c400);
    rdc(8'h88, 32'h0);
    tbr <= 1'b1;
    bus(1'b1, 8'h48, 32'h2e400);
    cyc(3);
    rdc(8'h88, 32'h0);
    tbr <= 1'b0;
    ow <= 16'h0;
    sp <= 16'h0;
    bus(1'b1, 8'h4c, 32'h12800);
    // second run: the field point ignores the pulse
    for (int b = 0; b < 2; b++)
    begin
      brk <= 16'(b) << 3;
      bus(1'b1, 8'h0c, 32'h8);
      n = 0;
      do
      begin
        bus(1'b0, 8'h8c, 32'h0);
        n++;
      end
      while (!q[3] && n < 60);
      chk(q & 32'hc, (32'(b) << 2) | 32'h8);
      bus(1'b1, 8'h0c, 32'h0);
      rdc(8'h8c, 32'h0);
    end
    // automatic mode: period of one auto_tick, broken point first
    bus(1'b1, 8'h00, 32'h0103);
    bus(1'b1, 8'h4c, 32'h13000);
    for (int b = 0; b < 2; b++)
    begin
      brk <= 16'(1 - b) << 3;
      at <= 1'b1;
      cyc(1);
      at <= 1'b0;
      cyc(50);
      rdc(8'h8c, 32'(1 - b) << 2);
    end
    test_done();
  end

  // whole sequence needs a few hundred cycles
  initial
  begin
    cyc(20000);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule

bind difd_top difd_top_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.mclk(mclk),
  .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .field_in(field_in), .comm_lost(comm_lost), .chan_val(chan_val),
  .pt_drive(pt_drive), .fault_req(fault_req));

`default_nettype wire

// file: logic/difd_chan.sv
/*
 one channel of the debounce filter; assumes a synchronised input
 and a half-millisecond tick pulse on the module clock.
*/
`timescale 1ns/1ps
`default_nettype none

module difd_chan (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic raw,
  input wire logic filt_en,
  input wire logic [7:0] steps,
  output logic filt
);

  difd_pkg::difd_flt_t q;
  difd_pkg::difd_flt_t next_q;

  always_comb
  begin
    next_q = q;
    if (!filt_en)
    begin
      next_q.filt = raw;
      next_q.last = raw;
      next_q.cnt = 8'h00;
    end
    else if (raw != q.last)
    begin
      next_q.last = raw;
      next_q.cnt = 8'h00;
    end
    else if (raw == q.filt)
      next_q.cnt = 8'h00;
    else if (tick)
    begin
      if ((q.cnt + 8'h01) >= steps)
      begin
        next_q.filt = raw;
        next_q.cnt = 8'h00;
      end
      else
        next_q.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign filt = q.filt;

endmodule

`default_nettype wire

// file: logic/difd_defs.svh
/*
 offsets, reset values and timing counts of the discrete input
 filter and diagnostic block; assumes a 25 ns module clock.
*/
`ifndef DIFD_DEFS_SVH
`define DIFD_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define DIFD_CLK_NS 25
`define DIFD_STEP_NS 500000
`define DIFD_STEP_CYC ((`DIFD_STEP_NS + `DIFD_CLK_NS - 1) / `DIFD_CLK_NS)
`define DIFD_STEPS_MIN 8'h01
`define DIFD_STEPS_MAX 8'hc8
`define DIFD_STEPS_DEF 8'h28
`define DIFD_PT_STEPS 8'h08

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DIFD_OFS_CTRL 8'h00
`define DIFD_OFS_VAL 8'h04
`define DIFD_OFS_MSTAT 8'h08
`define DIFD_OFS_PTCMD 8'h0c
`define DIFD_OFS_FAULT 8'h10
`define DIFD_REGION_GLB 2'h0
`define DIFD_REGION_CFG 2'h1
`define DIFD_REGION_DIAG 2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define DIFD_CTRL_RST 16'h0c03
`define DIFD_CHCFG_RST 18'h02051

`endif

// file: logic/difd_pkg.sv
/*
 types of the discrete input filter and diagnostic block;
 assumes difd_defs.svh for every number.
*/
`include "difd_defs.svh"
`default_nettype none

package difd_pkg;

  typedef enum logic [1:0] {DIFD_DUAL, DIFD_TRI, DIFD_QUAD} difd_itype_t;
  typedef enum logic [1:0] {DIFD_PT_OFF, DIFD_PT_MAN, DIFD_PT_AUTO} difd_ptmode_t;
  typedef enum logic {DIFD_PT_IDLE, DIFD_PT_RUN} difd_ptst_t;

  typedef struct packed {
    logic [7:0] auto_period;
    logic fp2_det;
    logic fp1_det;
    logic tb_loss_det;
    logic tb_faults;
    logic tb_default;
    logic comm_hold;
    logic stat_on;
    logic diag_on;
  } difd_ctrl_t;

  typedef struct packed {
    logic fault_en;
    logic ptf_en;
    logic sp_en;
    logic ow_en;
    logic diag_en;
    difd_ptmode_t pt_mode;
    difd_itype_t itype;
    logic [7:0] steps;
    logic filt_en;
  } difd_chcfg_t;

  typedef struct packed {
    logic [15:0] raw;
    logic [15:0] ow;
    logic [15:0] sp;
    logic tb;
    logic [1:0] fp;
  } difd_pins_t;

  typedef struct packed {
    logic filt;
    logic last;
    logic [7:0] cnt;
  } difd_flt_t;

  typedef struct packed {
    difd_pins_t s1;
    difd_pins_t s2;
    difd_ctrl_t ctrl;
    difd_chcfg_t [15:0] cfg;
    logic [15:0] ptcmd;
    logic [18:0] fault;
    logic [15:0] held;
    logic [15:0] chan_val;
    logic [15:0] auto_req;
    logic [15:0] pt_done;
    logic [15:0] pt_fail;
    difd_ptst_t pt_st;
    logic [3:0] pt_ch;
    logic [7:0] pt_cnt;
    logic pt_seen;
    logic [15:0] pt_drive;
    logic [1:0] pt_tail;
    logic [14:0] tick_cnt;
    logic tick;
    logic [7:0] auto_cnt;
    logic ack;
    logic [31:0] rdata;
  } difd_state_t;

endpackage

`default_nettype wire

// file: logic/difd_top.sv
/*
 16-channel discrete input conditioning: debounce filters, value
 defaulting, channel and module diagnostics, pulse test and fault
 flags, with registers on Avalon-MM. assumes field status pins are
 asynchronous and comm_lost and auto_tick come from logic on mclk.
*/
// Overview of operation
// - filter time 0.5 to 100 ms, half-ms steps
// - filter time defaults to 20 ms
// - per-channel filter enable, bypass passes raw input
// - accept state only after full stable interval
// - filtered values reported as sixteen-bit word
// - diag words per channel; length zero suppresses
// - module status word; length zero disables
// - comm loss forces off or holds last
// - terminal block removal forces defaults when enabled
// - enable keeps faults after terminal block removal
// - terminal block removal fault only when enabled
// - per-group field power loss detection enables
// - input type selects matching fault logging
// - diag data written only when enabled
// - open wire needs enable and tri/quad
// - short to power needs enable and quad
// - pulse test failures reported when enabled
// - fault table entries need fault enable
// - table entry needs table and diag enables
// - pulse test off, manual or automatic
// - completion held while command set, then cleared
`timescale 1ns/1ps
`default_nettype none
`include "difd_defs.svh"

module difd_top #(
  parameter int TICK_CYC = `DIFD_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] field_in,
  input wire logic [15:0] open_wire_in,
  input wire logic [15:0] short_pwr_in,
  input wire logic tb_removed_in,
  input wire logic [1:0] fp_lost_in,
  input wire logic comm_lost,
  input wire logic auto_tick,
  output logic [15:0] chan_val,
  output logic [15:0] pt_drive,
  output logic fault_req
);

  // ----------------------------------------
  // state and filters
  // ----------------------------------------
  difd_pkg::difd_state_t q;
  difd_pkg::difd_state_t next_q;
  logic [15:0] filt;
  logic [15:0] filt_in;
  logic [31:0] diag [16];
  logic [15:0] pt_mask;

  function automatic logic [7:0] clamp_steps(input logic [7:0] s);
    if (s < `DIFD_STEPS_MIN)
      return `DIFD_STEPS_MIN;
    else if (s > `DIFD_STEPS_MAX)
      return `DIFD_STEPS_MAX;
    else
      return s;
  endfunction

  // under pulse test the field input is meaningless, so hold the
  // accepted state instead of feeding the test pulse to the filter
  // the synchronisers lag the drive by two cycles, so the hold runs on
  // through pt_tail, else the pulse tail leaks into the value
  assign pt_mask = q.pt_drive | ((q.pt_tail != 2'h0) ? (16'h0001 << q.pt_ch) : 16'h0000);
  assign filt_in = (q.s2.raw & ~pt_mask) | (filt & pt_mask);

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_chan
      difd_chan u_chan (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(q.tick),
        .raw(filt_in[gi]),
        .filt_en(q.cfg[gi].filt_en),
        .steps(clamp_steps(q.cfg[gi].steps)),
        .filt(filt[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // diagnostic words
  // ----------------------------------------
  logic tb_gag;
  logic [15:0] ow_flag;
  logic [15:0] sp_flag;
  logic [15:0] ptf_flag;

  // faults after removal only when allowed
  assign tb_gag = q.s2.tb & ~q.ctrl.tb_faults;

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      ow_flag[i] = q.s2.ow[i] & q.cfg[i].ow_en & ~tb_gag
        & (q.cfg[i].itype != difd_pkg::DIFD_DUAL);
      sp_flag[i] = q.s2.sp[i] & q.cfg[i].sp_en & ~tb_gag
        & (q.cfg[i].itype == difd_pkg::DIFD_QUAD);
      ptf_flag[i] = q.pt_fail[i] & q.cfg[i].ptf_en & ~tb_gag;
      diag[i] = '0;
      if (q.ctrl.diag_on && q.cfg[i].diag_en)
      begin
        diag[i][0] = ow_flag[i];
        diag[i][1] = sp_flag[i];
        diag[i][2] = ptf_flag[i];
        diag[i][3] = q.pt_done[i];
        diag[i][4] = q.chan_val[i];
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic req;
  logic wr_go;
  logic [3:0] idx;
  logic [15:0] pend;
  logic [18:0] fault_set;
  logic [18:0] fault_clr;
  logic [31:0] mstat;
  logic [31:0] rd;
  logic found;

  assign req = avs_read | avs_write;
  assign wr_go = avs_write & q.ack;
  assign idx = avs_address[5:2];

  always_comb
  begin
    next_q = q;

    // two-flop synchronisers on field pins
    next_q.s1 = {field_in, open_wire_in, short_pwr_in, tb_removed_in, fp_lost_in};
    next_q.s2 = q.s1;

    // half-millisecond tick
    next_q.tick = 1'b0;
    if (q.tick_cnt == 15'(TICK_CYC - 1))
    begin
      next_q.tick_cnt = 15'h0000;
      next_q.tick = 1'b1;
    end
    else
      next_q.tick_cnt = q.tick_cnt + 15'h0001;

    // reported values
    if (comm_lost)
      next_q.chan_val = q.ctrl.comm_hold ? q.held : 16'h0000;
    else if (q.s2.tb && q.ctrl.tb_default)
      next_q.chan_val = 16'h0000;
    else
      next_q.chan_val = filt;
    if (!comm_lost)
      next_q.held = q.chan_val;

    // module status
    mstat = '0;
    if (q.ctrl.stat_on)
    begin
      mstat[0] = q.s2.tb;
      mstat[1] = q.s2.fp[0] & q.ctrl.fp1_det;
      mstat[2] = q.s2.fp[1] & q.ctrl.fp2_det;
      mstat[3] = comm_lost;
      mstat[4] = q.s2.tb & q.ctrl.tb_loss_det;
    end

    // fault flags: hardware set wins over software clear
    fault_set = '0;
    for (int i = 0; i < 16; i++)
      fault_set[i] = q.cfg[i].fault_en & ~tb_gag
        & (ow_flag[i] | sp_flag[i] | ptf_flag[i]);
    fault_set[16] = q.s2.tb & q.ctrl.tb_loss_det;
    fault_set[17] = q.s2.fp[0] & q.ctrl.fp1_det;
    fault_set[18] = q.s2.fp[1] & q.ctrl.fp2_det;
    fault_clr = '0;
    if (wr_go && avs_address == `DIFD_OFS_FAULT)
      fault_clr = avs_writedata[18:0];
    next_q.fault = (q.fault & ~fault_clr) | fault_set;

    // automatic pulse test scheduling
    if (auto_tick && q.ctrl.auto_period != 8'h00)
    begin
      if ((q.auto_cnt + 8'h01) >= q.ctrl.auto_period)
      begin
        next_q.auto_cnt = 8'h00;
        for (int i = 0; i < 16; i++)
          if (q.cfg[i].pt_mode == difd_pkg::DIFD_PT_AUTO)
            next_q.auto_req[i] = 1'b1;
      end
      else
        next_q.auto_cnt = q.auto_cnt + 8'h01;
    end

    // manual handshake and mode cleanup
    for (int i = 0; i < 16; i++)
    begin
      pend[i] = ((q.cfg[i].pt_mode == difd_pkg::DIFD_PT_MAN) & q.ptcmd[i]
        & ~q.pt_done[i]) | ((q.cfg[i].pt_mode == difd_pkg::DIFD_PT_AUTO)
        & q.auto_req[i]);
      if (q.cfg[i].pt_mode != difd_pkg::DIFD_PT_AUTO)
        next_q.auto_req[i] = 1'b0;
      if (q.cfg[i].pt_mode == difd_pkg::DIFD_PT_MAN && !q.ptcmd[i])
      begin
        next_q.pt_done[i] = 1'b0;
        next_q.pt_fail[i] = 1'b0;
      end
      if (q.cfg[i].pt_mode == difd_pkg::DIFD_PT_OFF)
      begin
        next_q.pt_done[i] = 1'b0;
        next_q.pt_fail[i] = 1'b0;
      end
    end

    // pulse test sequencer, one channel at a time
    found = 1'b0;
    case (q.pt_st)
      difd_pkg::DIFD_PT_IDLE:
      begin
        // no new test until the last pulse has left the synchronisers
        if (q.pt_tail != 2'h0)
          next_q.pt_tail = q.pt_tail - 2'h1;
        for (int i = 0; i < 16; i++)
        begin
          if (pend[i] && !found && q.pt_tail == 2'h0)
          begin
            found = 1'b1;
            next_q.pt_ch = 4'(i);
            next_q.pt_drive = 16'h0001 << i;
          end
        end
        if (found)
        begin
          next_q.pt_st = difd_pkg::DIFD_PT_RUN;
          next_q.pt_cnt = 8'h00;
          next_q.pt_seen = 1'b0;
        end
      end
      difd_pkg::DIFD_PT_RUN:
      begin
        if (q.s2.raw[q.pt_ch])
          next_q.pt_seen = 1'b1;
        if (q.tick)
          next_q.pt_cnt = q.pt_cnt + 8'h01;
        if (q.tick && (q.pt_cnt + 8'h01) >= `DIFD_PT_STEPS)
        begin
          next_q.pt_st = difd_pkg::DIFD_PT_IDLE;
          next_q.pt_drive = 16'h0000;
          next_q.auto_req[q.pt_ch] = 1'b0;
          next_q.pt_tail = 2'h2;
          // no valid field power means the test cannot pass
          next_q.pt_fail[q.pt_ch] = ~(q.pt_seen | q.s2.raw[q.pt_ch])
            | q.s2.fp[q.pt_ch[3]];
          if (q.cfg[q.pt_ch].pt_mode == difd_pkg::DIFD_PT_MAN)
            next_q.pt_done[q.pt_ch] = q.ptcmd[q.pt_ch];
        end
      end
      default:
      begin
        next_q.pt_st = difd_pkg::DIFD_PT_IDLE;
        next_q.pt_drive = 16'h0000;
      end
    endcase

    // register reads, unmapped addresses return zero
    rd = '0;
    case (avs_address[7:6])
      `DIFD_REGION_GLB:
      begin
        case (avs_address)
          `DIFD_OFS_CTRL: rd = {16'h0000, q.ctrl};
          `DIFD_OFS_VAL: rd = {16'h0000, q.chan_val};
          `DIFD_OFS_MSTAT: rd = mstat;
          `DIFD_OFS_PTCMD: rd = {16'h0000, q.ptcmd};
          `DIFD_OFS_FAULT: rd = {13'h0000, q.fault};
          default: rd = '0;
        endcase
      end
      `DIFD_REGION_CFG: rd = {14'h0000, q.cfg[idx]};
      `DIFD_REGION_DIAG: rd = diag[idx];
      default: rd = '0;
    endcase

    // one wait state per access
    next_q.ack = req & ~q.ack;
    // writes leave the last read data standing
    if (avs_read && !q.ack)
      next_q.rdata = rd;

    // register writes
    if (wr_go)
    begin
      if (avs_address == `DIFD_OFS_CTRL)
        next_q.ctrl = difd_pkg::difd_ctrl_t'(avs_writedata[15:0]);
      if (avs_address == `DIFD_OFS_PTCMD)
        next_q.ptcmd = avs_writedata[15:0];
      if (avs_address[7:6] == `DIFD_REGION_CFG)
        next_q.cfg[idx] = difd_pkg::difd_chcfg_t'(avs_writedata[17:0]);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.ctrl <= difd_pkg::difd_ctrl_t'(`DIFD_CTRL_RST);
      q.cfg <= {16{difd_pkg::difd_chcfg_t'(`DIFD_CHCFG_RST)}};
    end
    else
      q <= next_q;
  end

  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata = q.rdata;
  assign chan_val = q.chan_val;
  assign pt_drive = q.pt_drive;
  assign fault_req = |q.fault;

endmodule

`default_nettype wire
